// ===== rtl/ustr_pkg.sv
// How it works
// - buffer-empty flag is set when transmit buffer empty, cleared while it holds data
// - buffer-empty interrupt requested while its enable, the global enable and the flag are set
// - writing the data register while transmit is enabled loads the transmit buffer and clears buffer-empty
// - transmit-complete sets after the frame shifted out with no buffered data
// - transmit-complete clears on interrupt service or on software writing one
// - transmit-complete interrupt requested while its enable, the global enable and the flag are set
// - parity-enable inserts computed parity after last data bit, before stop bit
// - transmitter disable waits until buffer and shifter are empty, then releases pin
// - receive enable hands the receive pin to the receiver
// - synchronous mode receiver clocks on the external serial clock pin
// - reception starts on valid start bit, samples up to first stop bit only
// - after first stop bit the frame moves into the receive buffer
// - unused upper data bits read as zero for characters below eight bits
// - nine-bit mode stores ninth bit and error flags in the fifo per frame
// - shifter loads next character when idle or right after last stop bit
// - frame: start, data lsb first, optional parity, one or two stops; idle high
package ustr_pkg;
  // ======================================================
  // register map (word aligned byte addresses)
  localparam logic [3:0] ADDR_DATA = 4'h0;
  localparam logic [3:0] ADDR_CSA = 4'h4;
  localparam logic [3:0] ADDR_CSB = 4'h8;
  localparam logic [3:0] ADDR_CSC = 4'hc;
  localparam logic [3:0] ADDR_BAUD = 4'h0;
  // ======================================================
  // status register a bits
  localparam int CSA_PE = 2;
  localparam int CSA_DOR = 3;
  localparam int CSA_FE = 4;
  localparam int CSA_UDRE = 5;
  localparam int CSA_TXC = 6;
  localparam int CSA_RXC = 7;
  // control register b bits
  localparam int CSB_TX_NINTH_BIT = 0;
  localparam int CSB_RXB8 = 1;
  localparam int CSB_SZ2 = 2;
  localparam int CSB_TRANSMITTER_ENABLE = 3;
  localparam int CSB_RXEN = 4;
  localparam int CSB_UDRIE = 5;
  localparam int CSB_TXCIE = 6;
  localparam int CSB_RXCIE = 7;
  // control register c bits
  localparam int CSC_SZ0 = 1;
  localparam int CSC_STOP2 = 3;
  localparam int CSC_PM0 = 4;
  localparam int CSC_PM1 = 5;
  localparam int CSC_SYNC = 6;
  localparam int CSC_GIE = 7;
  // ======================================================
  // reset values
  localparam logic [7:0] CSB_RST = 8'h00;
  localparam logic [7:0] CSC_RST = 8'h06;
  localparam logic [11:0] BAUD_RST = 12'h000;
  localparam logic [3:0] SZ_NINE = 4'h7;
  localparam int RX_FIFO_DEPTH = 2;
endpackage

// ===== rtl/ustr_baud.sv
`timescale 1ns/1ps
`default_nettype none
module ustr_baud (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [11:0] div_i,
  output logic tick_o
);
  logic [11:0] cnt_reg;
  logic [11:0] cnt_next;
  logic tick_reg;
  logic tick_next;
  // ======================================================
  // shared divider: one tick per div_i+1 clocks
  always_comb begin
    tick_next = 1'b0;
    cnt_next = cnt_reg - 12'h001;
    if (cnt_reg == 12'h000) begin
      cnt_next = div_i;
      tick_next = 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= 12'h000;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end
  assign tick_o = tick_reg;
endmodule
`default_nettype wire

// ===== rtl/ustr_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ustr_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic d_i,
  output logic q_o
);
  logic [2:0] sh_reg;
  logic q_reg;
  // ======================================================
  // three stages; the value changes once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh_reg <= 3'h7;
      q_reg <= 1'b1;
    end else begin
      sh_reg <= {sh_reg[1:0], d_i};
      if (sh_reg[1] == sh_reg[2]) begin
        q_reg <= sh_reg[2];
      end
    end
  end
  assign q_o = q_reg;
endmodule
`default_nettype wire

// ===== rtl/ustr_top.sv
`timescale 1ns/1ps
`default_nettype none
module ustr_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic serial_in_pin_i,
  input wire logic serial_clock_pin_i,
  input wire logic tx_irq_ack_i,
  output logic serial_out_pin_o,
  output logic serial_out_pin_oe_o,
  output logic serial_in_pin_used_o,
  output logic irq_tx_empty_o,
  output logic irq_tx_complete_o,
  output logic irq_rx_complete_o
);
  localparam int DEPTH = ustr_pkg::RX_FIFO_DEPTH;
  // the pop logic only moves entry one into entry zero
  if (DEPTH != 2) begin : g_depth_chk
    $error("receive fifo depth must be 2");
  end
  // ======================================================
  // bus and registers
  logic [7:0] csb_reg, csb_next;
  logic [7:0] csc_reg, csc_next;
  logic [11:0] baud_reg, baud_next;
  logic ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;
  logic [8:0] txbuf_reg, txbuf_next;
  logic txfull_reg, txfull_next;
  logic txc_reg, txc_next;
  logic txact_reg, txact_next;
  logic [11:0] txsh_reg, txsh_next;
  logic [3:0] txcnt_reg, txcnt_next;
  logic tx_reg, tx_next;
  logic txoe_reg, txoe_next;
  logic irq_e_reg, irq_c_reg, irq_r_reg;
  logic tick, rxd, sck, sck_d_reg;
  logic [3:0] nbits;
  logic [3:0] tot;
  logic par_en, par_odd, transmitter_enable_eff, sync_mode;
  logic wr, rd, bus_req;
  logic [3:0] baddr;
  ustr_baud u_baud (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .div_i(baud_reg),
    .tick_o(tick)
  );
  ustr_sync u_rxd (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(serial_in_pin_i),
    .q_o(rxd)
  );
  ustr_sync u_sck (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(serial_clock_pin_i),
    .q_o(sck)
  );
  wire logic [3:0] szcode = {1'b0, csb_reg[ustr_pkg::CSB_SZ2], csc_reg[2:1]};
  wire logic nine = (szcode == ustr_pkg::SZ_NINE);
  always_comb begin
    case (szcode[1:0])
      2'h0: nbits = 4'h5;
      2'h1: nbits = 4'h6;
      2'h2: nbits = 4'h7;
      default: nbits = 4'h8;
    endcase
    if (nine) begin
      nbits = 4'h9;
    end
  end
  assign par_en = csc_reg[ustr_pkg::CSC_PM1];
  assign par_odd = csc_reg[ustr_pkg::CSC_PM0];
  assign sync_mode = csc_reg[ustr_pkg::CSC_SYNC];
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wr = bus_req & wb_we_i & wb_sel_i[0];
  assign rd = bus_req & ~wb_we_i;
  // the baud word decodes to a code that no 8-bit register uses
  assign baddr = wb_adr_i[4] ? 4'h1 : {wb_adr_i[3:2], 2'h0};
  // ======================================================
  // receiver state and fifo
  logic [8:0] fd_reg [DEPTH];
  logic [2:0] fs_reg [DEPTH];
  logic [8:0] fd_next [DEPTH];
  logic [2:0] fs_next [DEPTH];
  logic [1:0] fcnt_reg, fcnt_next;
  logic rxact_reg, rxact_next;
  logic [3:0] rxcnt_reg, rxcnt_next;
  logic [3:0] rxph_reg, rxph_next;
  logic [9:0] rxsh_reg, rxsh_next;
  logic dor_reg, dor_next;
  logic rx_bit_tick;
  wire logic rxen = csb_reg[ustr_pkg::CSB_RXEN];
  wire logic rxd_in = rxen ? rxd : 1'b1;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_d_reg <= 1'b0;
    end else begin
      sck_d_reg <= sck;
    end
  end
  // sync mode samples on the external clock, else on the shared tick
  assign rx_bit_tick = sync_mode ? (sck & ~sck_d_reg) : tick;
  assign tot = nbits + {3'h0, par_en};
  always_comb begin
    logic [8:0] dmask;
    logic perr;
    logic fe;
    dmask = 9'h000;
    perr = 1'b0;
    fe = 1'b0;
    rxact_next = rxact_reg;
    rxcnt_next = rxcnt_reg;
    rxph_next = rxph_reg;
    rxsh_next = rxsh_reg;
    dor_next = dor_reg;
    fcnt_next = fcnt_reg;
    for (int i = 0; i < DEPTH; i++) begin
      fd_next[i] = fd_reg[i];
      fs_next[i] = fs_reg[i];
    end
    // data read advances the fifo
    if (rd && baddr == ustr_pkg::ADDR_DATA && fcnt_reg != 2'h0) begin
      fd_next[0] = fd_reg[1];
      fs_next[0] = fs_reg[1];
      fcnt_next = fcnt_reg - 2'h1;
    end
    if (rx_bit_tick) begin
      if (!rxact_reg) begin
        if (!rxd_in) begin
          rxact_next = 1'b1;
          rxcnt_next = 4'h0;
          rxsh_next = 10'h000;
          if (fcnt_next == 2'(DEPTH)) begin
            dor_next = 1'b1;
          end
        end
      end else if (rxcnt_reg != tot) begin
        // lsb first: shift right from the top
        rxsh_next = {rxd_in, rxsh_reg[9:1]};
        rxcnt_next = rxcnt_reg + 4'h1;
      end else begin
        // first stop bit; a second one is ignored as idle
        rxact_next = 1'b0;
        fe = ~rxd_in;
        for (int b = 0; b < 9; b++) begin
          dmask[b] = (4'(b) < nbits);
        end
        rxsh_next = rxsh_reg >> (4'hA - tot);
        perr = par_en & (^(rxsh_next[8:0] & dmask) ^ par_odd ^ rxsh_next[nbits]);
        if (fcnt_next != 2'(DEPTH)) begin
          fd_next[fcnt_next[0]] = rxsh_next[8:0] & dmask;
          fs_next[fcnt_next[0]] = {fe, dor_reg, perr};
          fcnt_next = fcnt_next + 2'h1;
          dor_next = 1'b0;
        end
      end
    end
    if (!rxen) begin
      rxact_next = 1'b0;
      fcnt_next = 2'h0;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rxact_reg <= 1'b0;
      rxcnt_reg <= 4'h0;
      rxph_reg <= 4'h0;
      rxsh_reg <= 10'h000;
      dor_reg <= 1'b0;
      fcnt_reg <= 2'h0;
      for (int i = 0; i < DEPTH; i++) begin
        fd_reg[i] <= 9'h000;
        fs_reg[i] <= 3'h0;
      end
    end else begin
      rxact_reg <= rxact_next;
      rxcnt_reg <= rxcnt_next;
      rxph_reg <= rxph_next;
      rxsh_reg <= rxsh_next;
      dor_reg <= dor_next;
      fcnt_reg <= fcnt_next;
      fd_reg <= fd_next;
      fs_reg <= fs_next;
    end
  end
  // ======================================================
  // transmitter
  wire logic transmitter_enable_bit = csb_reg[ustr_pkg::CSB_TRANSMITTER_ENABLE];
  // disable deferred until buffer and shifter drain
  assign transmitter_enable_eff = transmitter_enable_bit | txfull_reg | txact_reg;
  always_comb begin
    logic [8:0] d;
    logic p;
    d = 9'h000;
    p = 1'b0;
    txbuf_next = txbuf_reg;
    txfull_next = txfull_reg;
    txc_next = txc_reg;
    txact_next = txact_reg;
    txsh_next = txsh_reg;
    txcnt_next = txcnt_reg;
    tx_next = tx_reg;
    txoe_next = transmitter_enable_eff;
    if (wr && baddr == ustr_pkg::ADDR_CSA && wb_dat_i[ustr_pkg::CSA_TXC]) begin
      txc_next = 1'b0;
    end
    if (irq_c_reg && tx_irq_ack_i) begin
      txc_next = 1'b0;
    end
    if (wr && baddr == ustr_pkg::ADDR_DATA && transmitter_enable_bit) begin
      txbuf_next = {csb_reg[ustr_pkg::CSB_TX_NINTH_BIT], wb_dat_i[7:0]};
      txfull_next = 1'b1;
    end
    if (tick) begin
      if (txact_reg) begin
        tx_next = txsh_reg[0];
        txsh_next = {1'b1, txsh_reg[11:1]};
        txcnt_next = txcnt_reg - 4'h1;
        if (txcnt_reg == 4'h1) begin
          txact_next = 1'b0;
          if (!txfull_reg) begin
            txc_next = 1'b1;
          end
        end
      end
      if ((!txact_reg || txcnt_reg == 4'h1) && txfull_reg) begin
        for (int b = 0; b < 9; b++) begin
          d[b] = txbuf_reg[b] & (4'(b) < nbits);
        end
        p = (^d) ^ par_odd;
        // stop bits fill from the idle-high top of the shifter
        txsh_next = 12'hfff;
        txsh_next[9:0] = {d, 1'b0} | ~(10'h3ff >> (4'h9 - nbits));
        if (par_en) begin
          txsh_next[nbits + 4'h1] = p;
        end
        txcnt_next = 4'h2 + tot + {3'h0, csc_reg[ustr_pkg::CSC_STOP2]};
        txact_next = 1'b1;
        txfull_next = 1'b0;
      end
    end
    if (!txact_next) begin
      tx_next = 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      txbuf_reg <= 9'h000;
      txfull_reg <= 1'b0;
      txc_reg <= 1'b0;
      txact_reg <= 1'b0;
      txsh_reg <= 12'hfff;
      txcnt_reg <= 4'h0;
      tx_reg <= 1'b1;
      txoe_reg <= 1'b0;
    end else begin
      txbuf_reg <= txbuf_next;
      txfull_reg <= txfull_next;
      txc_reg <= txc_next;
      txact_reg <= txact_next;
      txsh_reg <= txsh_next;
      txcnt_reg <= txcnt_next;
      tx_reg <= tx_next;
      txoe_reg <= txoe_next;
    end
  end
  // ======================================================
  // register writes, reads and interrupt requests
  logic [7:0] csa_val;
  logic irq_e_next, irq_c_next, irq_r_next;
  wire logic gie = csc_reg[ustr_pkg::CSC_GIE];
  always_comb begin
    csa_val = 8'h00;
    csa_val[ustr_pkg::CSA_RXC] = (fcnt_reg != 2'h0);
    csa_val[ustr_pkg::CSA_TXC] = txc_reg;
    csa_val[ustr_pkg::CSA_UDRE] = ~txfull_reg;
    csa_val[ustr_pkg::CSA_FE] = fs_reg[0][2];
    csa_val[ustr_pkg::CSA_DOR] = fs_reg[0][1];
    csa_val[ustr_pkg::CSA_PE] = fs_reg[0][0];
    csb_next = csb_reg;
    csc_next = csc_reg;
    baud_next = baud_reg;
    ack_next = bus_req;
    rdat_next = 32'h0000_0000;
    // writes to status register a touch only the clear-by-one bit
    if (wr) begin
      case (baddr)
        ustr_pkg::ADDR_CSB: csb_next = wb_dat_i[7:0];
        ustr_pkg::ADDR_CSC: csc_next = wb_dat_i[7:0];
        default: csb_next = csb_reg;
      endcase
      if (wb_adr_i[4] && wb_sel_i[1]) begin
        baud_next = wb_dat_i[11:0];
      end else if (wb_adr_i[4]) begin
        baud_next = {baud_reg[11:8], wb_dat_i[7:0]};
      end
    end
    if (rd) begin
      if (wb_adr_i[4]) begin
        rdat_next = {20'h00000, baud_reg};
      end else begin
        case (baddr)
          ustr_pkg::ADDR_DATA: rdat_next = {24'h000000, fd_reg[0][7:0]};
          ustr_pkg::ADDR_CSA: rdat_next = {24'h000000, csa_val};
          ustr_pkg::ADDR_CSB: rdat_next = {24'h000000, csb_reg[7:2], fd_reg[0][8], csb_reg[0]};
          default: rdat_next = {24'h000000, csc_reg};
        endcase
      end
    end
    irq_e_next = gie & csb_reg[ustr_pkg::CSB_UDRIE] & ~txfull_reg;
    irq_c_next = gie & csb_reg[ustr_pkg::CSB_TXCIE] & txc_reg;
    irq_r_next = gie & csb_reg[ustr_pkg::CSB_RXCIE] & (fcnt_reg != 2'h0);
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      csb_reg <= ustr_pkg::CSB_RST;
      csc_reg <= ustr_pkg::CSC_RST;
      baud_reg <= ustr_pkg::BAUD_RST;
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
      irq_e_reg <= 1'b0;
      irq_c_reg <= 1'b0;
      irq_r_reg <= 1'b0;
    end else begin
      csb_reg <= csb_next;
      csc_reg <= csc_next;
      baud_reg <= baud_next;
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
      irq_e_reg <= irq_e_next;
      irq_c_reg <= irq_c_next;
      irq_r_reg <= irq_r_next;
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;
  assign serial_out_pin_o = tx_reg;
  assign serial_out_pin_oe_o = txoe_reg;
  assign serial_in_pin_used_o = csb_reg[ustr_pkg::CSB_RXEN];
  assign irq_tx_empty_o = irq_e_reg;
  assign irq_tx_complete_o = irq_c_reg;
  assign irq_rx_complete_o = irq_r_reg;
endmodule
`default_nettype wire

// ===== bench/ustr_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ustr_top_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic tx_irq_ack_i,
  input wire logic serial_out_pin_o,
  input wire logic serial_out_pin_oe_o,
  input wire logic serial_in_pin_used_o,
  input wire logic irq_tx_complete_o
);
  // ====
  // shadow of ctrl b, taken at the answered write so it lags the device by one edge
  logic [7:0] cb_reg;
  logic [7:0] cb_next;
  logic wr_b;
  assign wr_b = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 5'h08;
  always_comb begin
    cb_next = wr_b ? wb_dat_i[7:0] : cb_reg;
  end
  always_ff @(posedge clk_i) begin
    cb_reg <= rst_i ? ustr_pkg::CSB_RST : cb_next;
  end
  default clocking
    @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ====
  // assertions
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_reset_quiet: assert property ($fell(rst_i) |-> serial_out_pin_o && !serial_out_pin_oe_o
    && !wb_ack_o && !irq_tx_complete_o)
    else $error("outputs not quiet after reset");
  a_txc_ack_clear: assert property (tx_irq_ack_i && irq_tx_complete_o
    |-> ##2 !irq_tx_complete_o)
    else $error("complete irq not cleared by service");
  a_rx_pin_used: assert property (wr_b |-> ##2
    serial_in_pin_used_o == cb_reg[ustr_pkg::CSB_RXEN])
    else $error("rx pin handover differs from enable");
  a_oe_with_en: assert property ($rose(serial_out_pin_oe_o)
    |-> cb_reg[ustr_pkg::CSB_TRANSMITTER_ENABLE] || cb_next[ustr_pkg::CSB_TRANSMITTER_ENABLE])
    else $error("tx pin taken while disabled");
  a_release_idle: assert property ($fell(serial_out_pin_oe_o) |-> $past(serial_out_pin_o)
    && !(cb_reg[ustr_pkg::CSB_TRANSMITTER_ENABLE] && cb_next[ustr_pkg::CSB_TRANSMITTER_ENABLE]))
    else $error("tx pin released mid frame or while enabled");
  c_wr: cover property (wb_ack_o && wb_we_i);
  c_txc: cover property ($rose(irq_tx_complete_o));
  c_rx: cover property ($rose(serial_in_pin_used_o));
endmodule
bind ustr_top ustr_top_chk i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .tx_irq_ack_i(tx_irq_ack_i), .serial_out_pin_o(serial_out_pin_o),
  .serial_out_pin_oe_o(serial_out_pin_oe_o), .serial_in_pin_used_o(serial_in_pin_used_o),
  .irq_tx_complete_o(irq_tx_complete_o)
);
`default_nettype wire

// ===== bench/ustr_line_model.sv
`timescale 1ns/1ps
`default_nettype none
module ustr_line_model #(
  parameter int BIT_CLKS = 8
) (
  input wire logic clk_i,
  input wire logic line_i,
  output logic line_o
);
  // ====
  // remote party: idles high, start low, bits lsb first
  logic [11:0] cap_q[$];
  logic [11:0] cap_bits;
  int cap_n = 10;
  initial line_o = 1'h1;
  task automatic send_frame(input logic [11:0] bits, input int n);
    line_o <= 1'h0;
    repeat (BIT_CLKS) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      line_o <= bits[i];
      repeat (BIT_CLKS) @(posedge clk_i);
    end
    line_o <= 1'h1;
  endtask
  // sample mid bit so the transmitter's tick phase does not matter
  always begin
    @(negedge line_i);
    cap_bits = 12'h000;
    repeat (BIT_CLKS / 2) @(posedge clk_i);
    for (int i = 0; i < cap_n; i++) begin
      repeat (BIT_CLKS) @(posedge clk_i);
      cap_bits[i] = line_i;
    end
    cap_q.push_back(cap_bits);
  end
endmodule
`default_nettype wire

// ===== bench/usart_tx_rx_datapath_tb.sv
`timescale 1ns/1ps
`default_nettype none
module usart_tx_rx_datapath_tb;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic cyc = 1'h0;
  logic stb = 1'h0;
  logic we = 1'h0;
  logic [4:0] adr = 5'h00;
  logic [31:0] dat_w = 32'h0;
  logic txc_ack = 1'h0;
  logic [31:0] dat_r;
  logic ack, tx_pin, tx_oe, rx_used, irq_e, irq_c, irq_r, rx_wire;
  logic tx_wire;
  int n_mismatch = 0;
  int samples_checked = 0;
  // a released tx pin floats to the idle level
  assign tx_wire = tx_oe ? tx_pin : 1'h1;
  initial forever #12.5 clk_i = ~clk_i;
  ustr_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
    .wb_ack_o(ack), .serial_in_pin_i(rx_wire), .serial_clock_pin_i(1'h0),
    .tx_irq_ack_i(txc_ack), .serial_out_pin_o(tx_pin), .serial_out_pin_oe_o(tx_oe),
    .serial_in_pin_used_o(rx_used), .irq_tx_empty_o(irq_e),
    .irq_tx_complete_o(irq_c), .irq_rx_complete_o(irq_r));
  ustr_line_model #(.BIT_CLKS(8)) i_line (.clk_i(clk_i), .line_i(tx_wire), .line_o(rx_wire));
  // ====
  // tasks
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    dat_w <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'h1 && n < 40);
    q = dat_r;
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge clk_i);
    if (n >= 40) begin
      chk("ack", 32'h1, 32'h0);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'h1, a, d, q);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e, input string what);
    logic [31:0] q;
    xfer(1'h0, a, 32'h0, q);
    chk(what, e, q);
  endtask
  task automatic tx_expect(input int n, input logic [11:0] e);
    int k;
    k = 0;
    while (i_line.cap_q.size() < n && k < 400) begin
      @(posedge clk_i);
      k++;
    end
    chk("frame", {20'h0, e}, {20'h0, i_line.cap_q[n-1]});
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    give_verdict();
  end
  // ====
  // tests
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    chk("tx oe", 32'h0, tx_oe);
    rd(5'h04, 32'h20, "status");
    rd(5'h08, {24'h0, ustr_pkg::CSB_RST}, "ctrl b");
    rd(5'h0c, {24'h0, ustr_pkg::CSC_RST}, "ctrl c");
    rd(5'h10, 32'h0, "baud");
    $display("test reset done");
    wr(5'h10, 32'h7);
    wr(5'h0c, 32'ha6);
    wr(5'h08, 32'h58);
    wr(5'h00, 32'ha5);
    repeat (12) @(posedge clk_i);
    wr(5'h00, 32'h07);
    rd(5'h04, 32'h00, "status");
    tx_expect(1, 12'h2a5);
    tx_expect(2, 12'h307);
    repeat (16) @(posedge clk_i);
    rd(5'h04, 32'h60, "status");
    chk("irq complete", 32'h1, irq_c);
    txc_ack <= 1'h1;
    @(posedge clk_i);
    txc_ack <= 1'h0;
    repeat (3) @(posedge clk_i);
    chk("irq complete", 32'h0, irq_c);
    $display("test transmit done");
    wr(5'h00, 32'h81);
    wr(5'h08, 32'h50);
    chk("tx oe", 32'h1, tx_oe);
    tx_expect(3, 12'h281);
    repeat (16) @(posedge clk_i);
    chk("tx oe", 32'h0, tx_oe);
    rd(5'h04, 32'h60, "status");
    wr(5'h04, 32'h40);
    rd(5'h04, 32'h20, "status");
    wr(5'h08, 32'h30);
    repeat (3) @(posedge clk_i);
    chk("irq empty", 32'h1, irq_e);
    wr(5'h0c, 32'h26);
    repeat (3) @(posedge clk_i);
    chk("irq empty", 32'h0, irq_e);
    $display("test disable done");
    chk("rx used", 32'h1, rx_used);
    i_line.send_frame(12'h63c, 11);
    repeat (24) @(posedge clk_i);
    rd(5'h04, 32'ha0, "status");
    rd(5'h00, 32'h3c, "rx data");
    wr(5'h0c, 32'h00);
    i_line.send_frame(12'h035, 6);
    repeat (24) @(posedge clk_i);
    rd(5'h00, 32'h15, "rx data");
    $display("test receive done");
    wr(5'h0c, 32'h26);
    wr(5'h08, 32'h1d);
    i_line.cap_n = 11;
    wr(5'h00, 32'h55);
    tx_expect(4, 12'h755);
    i_line.send_frame(12'h7ab, 11);
    repeat (24) @(posedge clk_i);
    rd(5'h04, 32'he4, "status");
    rd(5'h08, 32'h1f, "ctrl b");
    rd(5'h00, 32'hab, "rx data");
    rd(5'h04, 32'h60, "status");
    $display("test nine bit done");
    give_verdict();
  end
endmodule
`default_nettype wire
